//--- dpwc_pkg.sv
// Constants shared by the wiper command control block
package dpwc_pkg;
  localparam int unsigned WORD_W   = 24;
  localparam int unsigned CNT_W    = 5;
  localparam int unsigned WIPER_W  = 10;
  localparam int unsigned TAPS     = 1024;
  localparam int unsigned OP_HI    = 23;
  localparam int unsigned OP_LO    = 16;
  localparam int unsigned NIB_LO   = 20;
  localparam logic [CNT_W-1:0]   FRAME_BITS = 5'h18;
  localparam logic [CNT_W-1:0]   CNT_MAX    = 5'h1f;
  localparam logic [7:0]         OP_LOAD    = 8'hb0;
  localparam logic [7:0]         OP_INC     = 8'he0;
  localparam logic [7:0]         OP_STORE   = 8'h20;
  localparam logic [7:0]         OP_RESTORE = 8'h10;
  localparam logic [3:0]         NIB_RESET  = 4'h8;
  localparam logic [WIPER_W-1:0] WIPER_MAX  = 10'h3ff;
  localparam logic [WIPER_W-1:0] WIPER_ONE  = 10'h001;
  localparam logic [WIPER_W-1:0] NV_INIT    = 10'h000;
  localparam logic [WORD_W-1:0]  WORD_ZERO  = 24'h000000;
endpackage

//--- dpwc_cmd_if.sv
// Received command word and serial echo bit between link and core
`timescale 1ns/1ps
`default_nettype none
interface dpwc_cmd_if;
  logic                         valid;
  logic [dpwc_pkg::WORD_W-1:0]  word;
  logic                         echo_bit;
  modport src (output valid, output word, output echo_bit);
  modport dst (input valid, input word, input echo_bit);
endinterface
`default_nettype wire

//--- dpwc_link.sv
// Serial frame receiver and echo shifter, oversampling the link clock
`timescale 1ns/1ps
`default_nettype none
module dpwc_link (
  // Clock and reset
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  // Serial pins
  input  wire logic sclk_in,
  input  wire logic cs_n_in,
  input  wire logic serial_in,
  // Core side
  dpwc_cmd_if.src   cmd
);
  logic [2:0] s1;
  logic [2:0] s2;
  logic       sclk_d;
  logic       cs_n_d;
  logic [dpwc_pkg::WORD_W-1:0] in_shift, out_shift, prev_word;
  logic [dpwc_pkg::CNT_W-1:0]  cnt;
  logic                        valid, echo_bit;
  logic [dpwc_pkg::WORD_W-1:0] next_in_shift, next_out_shift, next_prev_word;
  logic [dpwc_pkg::CNT_W-1:0]  next_cnt;
  logic                        next_valid, next_echo_bit;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise;

  // Second stage only feeds logic; first stage is read by nothing else
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      s1     <= 3'h7;
      s2     <= 3'h7;
      sclk_d <= 1'b1;
      cs_n_d <= 1'b1;
    end else begin
      s1     <= {sclk_in, cs_n_in, serial_in};
      s2     <= s1;
      sclk_d <= s2[2];
      cs_n_d <= s2[1];
    end
  end

  assign sclk_rise = s2[2] & ~sclk_d & ~s2[1];
  assign sclk_fall = ~s2[2] & sclk_d & ~s2[1];
  assign cs_fall   = ~s2[1] & cs_n_d;
  assign cs_rise   = s2[1] & ~cs_n_d;

  always_comb begin
    next_in_shift  = in_shift;
    next_out_shift = out_shift;
    next_prev_word = prev_word;
    next_cnt       = cnt;
    next_valid     = 1'b0;
    next_echo_bit  = echo_bit;
    if (cs_fall) begin
      next_cnt       = '0;
      next_out_shift = prev_word;
      next_echo_bit  = prev_word[dpwc_pkg::WORD_W-1];
    end else if (cs_rise) begin
      // Frames of any other length are dropped and not echoed
      if (cnt == dpwc_pkg::FRAME_BITS) begin
        next_prev_word = in_shift;
        next_valid     = 1'b1;
      end
    end else if (sclk_rise) begin
      next_in_shift = {in_shift[dpwc_pkg::WORD_W-2:0], s2[0]};
      if (cnt != dpwc_pkg::CNT_MAX) begin
        next_cnt = cnt + 5'h01;
      end
    end else if (sclk_fall) begin
      next_out_shift = {out_shift[dpwc_pkg::WORD_W-2:0], 1'b0};
      next_echo_bit  = out_shift[dpwc_pkg::WORD_W-2];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      in_shift  <= dpwc_pkg::WORD_ZERO;
      out_shift <= dpwc_pkg::WORD_ZERO;
      prev_word <= dpwc_pkg::WORD_ZERO;
      cnt       <= '0;
      valid     <= 1'b0;
      echo_bit  <= 1'b0;
    end else begin
      in_shift  <= next_in_shift;
      out_shift <= next_out_shift;
      prev_word <= next_prev_word;
      cnt       <= next_cnt;
      valid     <= next_valid;
      echo_bit  <= next_echo_bit;
    end
  end

  assign cmd.valid    = valid;
  assign cmd.word     = prev_word;
  assign cmd.echo_bit = echo_bit;

  sequence s_frame_open;
    cs_fall;
  endsequence
  sequence s_echo_loaded;
    ##1 (out_shift == $past(prev_word)) &&
        (echo_bit == $past(prev_word[dpwc_pkg::WORD_W-1]));
  endsequence
  a_echo_frame_load: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    s_frame_open |-> s_echo_loaded)
    else $error("echo word not loaded at frame start");
  a_word_capture: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    cs_rise && cnt == dpwc_pkg::FRAME_BITS |=>
    valid && prev_word == $past(in_shift))
    else $error("complete frame not captured");
endmodule
`default_nettype wire

//--- dpwc_core.sv
// Wiper command control: decode, wiper register, store, tap select
`timescale 1ns/1ps
`default_nettype none
module dpwc_core (
  // Clock and reset
  input  wire logic                         core_clk_in,
  input  wire logic                         rst_n_in,
  // Serial link
  input  wire logic                         sclk_in,
  input  wire logic                         cs_n_in,
  input  wire logic                         serial_in,
  output logic                              serial_out,
  // Control pins
  input  wire logic                         wp_n_in,
  input  wire logic                         preset_strobe_n_in,
  // Switch array
  output logic                              sw_a_out,
  output logic                              sw_b_out,
  output logic [dpwc_pkg::TAPS-1:0]         tap_sel_out,
  output logic [dpwc_pkg::WIPER_W-1:0]      wiper_out
);
  dpwc_cmd_if cmd_bus ();

  dpwc_link u_link (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .sclk_in     (sclk_in),
    .cs_n_in     (cs_n_in),
    .serial_in   (serial_in),
    .cmd         (cmd_bus)
  );

  logic [1:0]                    wp_s1, wp_s2;
  logic                          wp_ok, preset_act;
  logic                          boot;
  logic [dpwc_pkg::WIPER_W-1:0]  wiper_setting_register;
  logic [dpwc_pkg::WIPER_W-1:0]  nonvolatile_store;
  logic [dpwc_pkg::TAPS-1:0]     tap_sel;
  logic                          echo_pin;
  // End switches sit in a flop so that every pin leaves a register
  logic                          ends_on;
  logic [dpwc_pkg::WIPER_W-1:0]  next_wiper;
  logic [dpwc_pkg::WIPER_W-1:0]  next_nv;
  logic [dpwc_pkg::TAPS-1:0]     next_tap;
  logic [7:0]                    op;

  // Pins are asynchronous to the core clock
  // Both are slow levels, so one shared two-stage chain is enough
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      wp_s1 <= 2'h3;
      wp_s2 <= 2'h3;
    end else begin
      wp_s1 <= {wp_n_in, preset_strobe_n_in};
      wp_s2 <= wp_s1;
    end
  end
  assign wp_ok      = wp_s2[1];
  assign preset_act = ~wp_s2[0];

  assign op = cmd_bus.word[dpwc_pkg::OP_HI:dpwc_pkg::OP_LO];

  always_comb begin
    next_wiper = wiper_setting_register;
    next_nv    = nonvolatile_store;
    if (boot || preset_act) begin
      next_wiper = nonvolatile_store;
    end else if (cmd_bus.valid) begin
      if (op == dpwc_pkg::OP_LOAD) begin
        next_wiper = cmd_bus.word[dpwc_pkg::WIPER_W-1:0];
      end else if (op == dpwc_pkg::OP_INC) begin
        // Saturate rather than wrap: a wrap would jump full to zero scale
        if (wiper_setting_register != dpwc_pkg::WIPER_MAX) begin
          next_wiper = wiper_setting_register + dpwc_pkg::WIPER_ONE;
        end
      end else if (op == dpwc_pkg::OP_STORE) begin
        if (wp_ok) begin
          next_nv = wiper_setting_register;
        end
      end else if (op == dpwc_pkg::OP_RESTORE ||
                   cmd_bus.word[dpwc_pkg::OP_HI:dpwc_pkg::NIB_LO] ==
                   dpwc_pkg::NIB_RESET) begin
        next_wiper = nonvolatile_store;
      end
    end
  end

  // One comparator per tap; the decoded word is registered before the pins
  genvar gi;
  generate
    for (gi = 0; gi < dpwc_pkg::TAPS; gi++) begin : g_tap
      assign next_tap[gi] = (wiper_setting_register ==
                             dpwc_pkg::WIPER_W'(gi));
    end
  endgenerate

  // Storage keeps its value under reset only in a real part; here reset
  // stands in for power-on and reloads the default
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      boot                   <= 1'b1;
      wiper_setting_register <= dpwc_pkg::NV_INIT;
      nonvolatile_store      <= dpwc_pkg::NV_INIT;
      tap_sel                <= '0;
      echo_pin               <= 1'b0;
      ends_on                <= 1'b1;
    end else begin
      boot                   <= 1'b0;
      wiper_setting_register <= next_wiper;
      nonvolatile_store      <= next_nv;
      tap_sel                <= next_tap;
      echo_pin               <= cmd_bus.echo_bit;
      ends_on                <= 1'b1;
    end
  end

  assign serial_out  = echo_pin;
  assign sw_a_out    = ends_on;
  assign sw_b_out    = ends_on;
  assign tap_sel_out = tap_sel;
  assign wiper_out   = wiper_setting_register;

  a_tap_one_hot: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    !boot |=> $onehot(tap_sel))
    else $error("tap select not one-hot");
  a_ends_closed: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    sw_a_out && sw_b_out)
    else $error("end switch opened");
  a_tap_index: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    1'b1 |=> tap_sel[$past(wiper_setting_register)])
    else $error("wrong tap selected");
  a_load_wiper: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    cmd_bus.valid && op == dpwc_pkg::OP_LOAD && !boot && !preset_act
    |=> wiper_setting_register ==
        $past(cmd_bus.word[dpwc_pkg::WIPER_W-1:0]))
    else $error("load command not applied");
  a_inc_step: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    cmd_bus.valid && op == dpwc_pkg::OP_INC && !boot && !preset_act &&
    wiper_setting_register != dpwc_pkg::WIPER_MAX
    |=> wiper_setting_register ==
        $past(wiper_setting_register) + dpwc_pkg::WIPER_ONE)
    else $error("increment not by one");
  a_store_copy: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    cmd_bus.valid && op == dpwc_pkg::OP_STORE && wp_ok && !boot &&
    !preset_act
    |=> nonvolatile_store == $past(wiper_setting_register))
    else $error("store command not applied");
  a_protect_store: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    !wp_ok |=> $stable(nonvolatile_store))
    else $error("protected store changed");
  a_preset_load: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    preset_act ##1 preset_act
    |-> wiper_setting_register == nonvolatile_store)
    else $error("preset did not restore wiper");
  a_inc_saturate: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    cmd_bus.valid && op == dpwc_pkg::OP_INC && !preset_act &&
    wiper_setting_register == dpwc_pkg::WIPER_MAX
    |=> wiper_setting_register == dpwc_pkg::WIPER_MAX)
    else $error("increment wrapped at full scale");
  a_boot_restore: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    boot |=> wiper_setting_register == $past(nonvolatile_store))
    else $error("power-on restore missing");
  a_preset_wins: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    preset_act |=> wiper_setting_register == $past(nonvolatile_store))
    else $error("preset did not override commands");
  a_restore_cmd: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    cmd_bus.valid && !boot && !preset_act &&
    (op == dpwc_pkg::OP_RESTORE ||
     cmd_bus.word[dpwc_pkg::OP_HI:dpwc_pkg::NIB_LO] == dpwc_pkg::NIB_RESET)
    |=> wiper_setting_register == $past(nonvolatile_store))
    else $error("restore command not applied");
  // A stray write path would move the wiper between frames
  a_wiper_idle: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    !cmd_bus.valid && !boot && !preset_act
    |=> $stable(wiper_setting_register))
    else $error("wiper changed without a command");
  a_store_idle: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    !(cmd_bus.valid && op == dpwc_pkg::OP_STORE)
    |=> $stable(nonvolatile_store))
    else $error("store changed without a store command");

  // Load and increment reach the tap pins two edges after the pulse
  sequence s_load_taken;
    cmd_bus.valid && op == dpwc_pkg::OP_LOAD && !boot && !preset_act;
  endsequence
  sequence s_inc_taken;
    cmd_bus.valid && op == dpwc_pkg::OP_INC && !boot && !preset_act;
  endsequence
  sequence s_below_top;
    wiper_setting_register != dpwc_pkg::WIPER_MAX;
  endsequence
  a_load_to_tap: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    s_load_taken |=> ##1
      tap_sel[$past(cmd_bus.word[dpwc_pkg::WIPER_W-1:0], 2)])
    else $error("loaded code not on tap select");
  a_inc_to_tap: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    s_inc_taken ##0 s_below_top |=> ##1
      tap_sel[$past(wiper_setting_register, 2) + dpwc_pkg::WIPER_ONE])
    else $error("increment not on next tap");
endmodule
`default_nettype wire

//--- dpwc_host.sv
// Host model that drives command frames on the serial link
`timescale 1ns/1ps
`default_nettype none
module dpwc_host (
  // Timing reference
  input  wire logic clk_in,
  // Serial pins
  input  wire logic serial_out_in,
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      serial_in_out
);
  initial begin
    sclk_out      = 1'b0;
    cs_n_out      = 1'b1;
    serial_in_out = 1'b0;
  end
  task automatic hc(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask
  // Echo bits are taken late in the high phase, after they have settled
  // Frame of n bits, most significant first; any n is sent, and the link drops n other than 24
  task automatic frame(input logic [31:0] w, input int n,
                       output logic [31:0] e);
    e = 32'h00000000;
    cs_n_out = 1'b0;
    hc(4);
    for (int i = n - 1; i >= 0; i--) begin
      serial_in_out = w[i];
      hc(4);
      sclk_out = 1'b1;
      hc(4);
      e[i] = serial_out_in;
      sclk_out = 1'b0;
    end
    hc(4);
    cs_n_out = 1'b1;
    // Released line shows the opposite level, never a stale bit
    serial_in_out = ~w[0];
    hc(8);
  endtask
  task automatic send(input logic [23:0] w, output logic [23:0] e);
    logic [31:0] e32;
    frame({8'h00, w}, 24, e32);
    e = e32[23:0];
  endtask
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the wiper command control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic          clk   = 1'b0;
  logic          rst_n = 1'b0;
  logic          wp_n  = 1'b1;
  logic          pre_n = 1'b1;
  logic          sclk;
  logic          cs_n;
  logic          sdat;
  logic          sout;
  logic          sw_a;
  logic          sw_b;
  logic [1023:0] tap;
  logic [9:0]    wiper;
  logic [9:0]    wm    = 10'h000;
  logic [9:0]    nvm   = 10'h000;
  logic [23:0]   prev  = 24'h000000;
  logic [23:0]   lastx = 24'h000000;
  logic [23:0]   echo  = 24'h000000;
  logic [33:0]   exp_q[$];
  event          res_ev;
  int            fail_count = 0;
  int            checks     = 0;
  int            seed       = 4;
  int            cyc        = 0;
  always #20 clk = ~clk;
  dpwc_core u_dpwc_core (
    .core_clk_in(clk), .rst_n_in(rst_n), .sclk_in(sclk), .cs_n_in(cs_n),
    .serial_in(sdat), .serial_out(sout), .wp_n_in(wp_n),
    .preset_strobe_n_in(pre_n), .sw_a_out(sw_a), .sw_b_out(sw_b),
    .tap_sel_out(tap), .wiper_out(wiper));
  dpwc_host u_dpwc_host (
    .clk_in(clk), .serial_out_in(sout), .sclk_out(sclk),
    .cs_n_out(cs_n), .serial_in_out(sdat));
  task automatic chk(input logic [1023:0] seen, input logic [1023:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic note(input logic [9:0] wx);
    exp_q.push_back({lastx, wx});
    -> res_ev;
  endtask
  task automatic cmd(input logic [7:0] op, input logic [15:0] d);
    case (op)
      8'hb0: wm = d[9:0];
      8'he0: if (wm !== 10'h3ff) wm = wm + 10'h001;
      8'h20: if (wp_n) nvm = wm;
      default: wm = nvm;
    endcase
    u_dpwc_host.send({op, d}, echo);
    lastx = prev;
    prev = {op, d};
    note(wm);
  endtask
  always @(res_ev) begin : watch
    logic [33:0] n;
    n = exp_q.pop_front();
    chk(wiper, n[9:0]);
    chk(tap, 1024'h1 << n[9:0]);
    chk({sw_a, sw_b}, 2'h3);
    chk(echo, n[33:10]);
  end
  // Ceiling is about four times the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    logic [15:0] r;
    logic [31:0] e32;
    repeat (12) @(posedge clk);
    #2;
    chk({sw_a, sw_b}, 2'h3);
    rst_n = 1'b1;
    repeat (6) @(posedge clk);
    #2;
    note(10'h000);
    $display("test boot done");
    cmd(8'hb0, 16'h0100);
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      cmd(8'hb0, {6'h00, r[9:0]});
    end
    cmd(8'hb0, 16'h0000);
    // A 25-bit load frame must be dropped and never echoed later
    r = $random(seed);
    u_dpwc_host.frame({8'h01, 8'hb0, 6'h00, r[9:1], 1'b1}, 25, e32);
    chk(e32[24:1], prev);
    note(wm);
    $display("test load done");
    cmd(8'hb0, 16'h03fd);
    for (int i = 0; i < 3; i++) begin
      r = $random(seed);
      cmd(8'he0, r);
    end
    $display("test increment done");
    cmd(8'hb0, 16'h0155);
    r = $random(seed);
    cmd(8'h20, r);
    cmd(8'hb0, 16'h00aa);
    pre_n = 1'b0;
    repeat (4) @(posedge clk);
    #2;
    pre_n = 1'b1;
    repeat (4) @(posedge clk);
    #2;
    wm = nvm;
    note(wm);
    cmd(8'hb0, 16'h00aa);
    r = $random(seed);
    cmd(8'h10, r);
    cmd(8'hb0, 16'h00aa);
    r = $random(seed);
    cmd({4'h8, r[3:0]}, r);
    $display("test store restore done");
    wp_n = 1'b0;
    cmd(8'hb0, 16'h02aa);
    cmd(8'h20, r);
    cmd(8'h10, r);
    wp_n = 1'b1;
    $display("test protect done");
    repeat (2) @(posedge clk);
    end_of_test();
  end
endmodule
`default_nettype wire
